// ### common/efdl_cfg.svh
// constants for the engine flight data logger: offsets, fields, reset values, timing
`ifndef EFDL_CFG_SVH
`define EFDL_CFG_SVH
// register byte offsets
`define EFDL_CTRL_OFF       12'h000
`define EFDL_IVAL_OFF       12'h004
`define EFDL_ACID_OFF       12'h008
`define EFDL_TIME_OFF       12'h00C
`define EFDL_STAT_OFF       12'h010
`define EFDL_WPTR_OFF       12'h014
`define EFDL_DUMP_OFF       12'h018
`define EFDL_RDAT_OFF       12'h01C
`define EFDL_SENS_OFF       12'h020
`define EFDL_SCAN_OFF       12'h024
`define EFDL_FUEL_OFF       12'h028
`define EFDL_CALC_OFF       12'h02C
// control fields
`define EFDL_CTRL_ACCUM     0
`define EFDL_CTRL_CDT_INST  1
`define EFDL_CTRL_NAV_OK    2
`define EFDL_CTRL_REFUEL    3
`define EFDL_CTRL_BIT       4
// reset values, limits and timing
`define EFDL_IVAL_RST       9'h006
`define EFDL_IVAL_MIN       9'h002
`define EFDL_IVAL_MAX       9'h1F4
`define EFDL_ACID_RST       32'h0000_1234
`define EFDL_EGT_START      12'h1F4
`define EFDL_CLK_HZ         40000000
`define EFDL_SEC_NS         1000000000
`define EFDL_CLK_NS         25
`define EFDL_SEC_CYC        (`EFDL_SEC_NS / `EFDL_CLK_NS)
`define EFDL_MEM_DEPTH      64
`define EFDL_ITEM_CNT       21
`endif

// ### common/efdl_pkg.sv
// types for the engine flight data logger
package efdl_pkg;
  typedef enum logic [3:0] {
    EFDL_IDLE  = 4'b0001,
    EFDL_MENU  = 4'b0010,
    EFDL_XFER  = 4'b0100,
    EFDL_DONE  = 4'b1000
  } efdl_dump_t;
  typedef enum logic [1:0] {
    EFDL_SW_TEMP = 2'h0,
    EFDL_SW_ALL  = 2'h1,
    EFDL_SW_FUEL = 2'h2
  } efdl_sw_t;
  typedef enum logic [1:0] {
    EFDL_OPT_NEW  = 2'h0,
    EFDL_OPT_ALL  = 2'h1,
    EFDL_OPT_EXIT = 2'h2
  } efdl_opt_t;
endpackage

// ### hdl/efdl_logger.sv
// engine flight data logger with record memory, download control and scan filter
`timescale 1ns/100ps
`include "efdl_cfg.svh"
// Notes on behaviour
// RQ1: store one packed record of displayed values every interval, six seconds by default
// RQ2: interval programmable from 2 to 500 seconds at any time
// RQ3: interval change in flight closes the flight and opens a new one
// RQ4: recording starts only when exhaust temperature exceeds 500 F
// RQ5: full memory wraps, oldest record overwritten
// RQ6: each record carries the settable real-time clock value; the record keeps only rtc[11:0]
// RQ7: aircraft identifier programmable, reset to serial number, sent with downloads
// RQ8: downloading never erases stored records
// RQ9: drive insertion offers new, all, or exit
// RQ10: download starts on insertion only when no alarm pending
// RQ11: select button cycles options, step button executes
// RQ12: progress percent shown during download, then done, then normal
// RQ13: built-in test shows date, time, memory filled percent and identifier; the status percent counts records since the last download (fill_new)
// RQ14: speed and pressure item shown one second in every switch position
// RQ15: carburetor item skipped when compressor outlet sensor fitted
// RQ16: waypoint fuel items shown only with valid navigation and waypoint
// RQ17: exhaust spread is hottest minus coldest, marking widest deviating cylinder
// RQ18: endurance is fuel left over burn rate as hours and minutes
// RQ19: fuel used counts since refuel or as trip total
// RQ20: switch limits scan to temperature, fuel or both items
// RQ21: alarms shown whatever the switch position
// RQ22: seconds counter from clock tick reloaded from interval after each record
module efdl_logger
(
  input  wire logic             CLOCK,
  input  wire logic             SYS_RST,
  input  wire logic [11:0]      PADDR,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic [11:0]      EGT_HOT,
  input  wire logic [11:0]      EGT_COLD,
  input  wire logic [2:0]       HOT_CYL,
  input  wire logic [2:0]       COLD_CYL,
  input  wire logic [11:0]      EGT_AVG,
  input  wire logic             DRIVE_PRESENT,
  input  wire logic             SELECT_BUTTON,
  input  wire logic             STEP_BUTTON,
  input  wire logic             ALARM_PENDING,
  input  wire logic [1:0]       SELECT_SWITCH,
  input  wire logic             DRIVE_READY,
  output logic                  DRIVE_VALID,
  output logic      [31:0]      DRIVE_DATA,
  output logic      [1:0]       DUMP_CHOICE,
  output logic      [6:0]       DUMP_PERCENT,
  output logic                  DUMP_DONE,
  output logic      [4:0]       SCAN_ITEM,
  output logic                  SCAN_ALARM,
  output logic      [11:0]      SPREAD_VALUE,
  output logic      [2:0]       SPREAD_CYL
);
  import efdl_pkg::*;

  localparam int SEC_CYC = `EFDL_SEC_CYC;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] s_drv, s_sel, s_stp, s_alm;
  logic [1:0] sw_a, sw_b, sw_c;
  logic       drv, sel, stp, alm, drv_q, sel_q, stp_q;
  logic [1:0] sw;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      s_drv <= 3'h0; s_sel <= 3'h0; s_stp <= 3'h0; s_alm <= 3'h0;
      sw_a <= 2'h0; sw_b <= 2'h0; sw_c <= 2'h0;
      drv <= 1'b0; sel <= 1'b0; stp <= 1'b0; alm <= 1'b0; sw <= 2'h0;
    end
    else
    begin
      s_drv <= {s_drv[1:0], DRIVE_PRESENT};
      s_sel <= {s_sel[1:0], SELECT_BUTTON};
      s_stp <= {s_stp[1:0], STEP_BUTTON};
      s_alm <= {s_alm[1:0], ALARM_PENDING};
      sw_a <= SELECT_SWITCH; sw_b <= sw_a; sw_c <= sw_b;
      if (s_drv[1] == s_drv[2]) drv <= s_drv[2];
      if (s_sel[1] == s_sel[2]) sel <= s_sel[2];
      if (s_stp[1] == s_stp[2]) stp <= s_stp[2];
      if (s_alm[1] == s_alm[2]) alm <= s_alm[2];
      if (sw_b == sw_c) sw <= sw_c;
    end
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      drv_q <= 1'b0; sel_q <= 1'b0; stp_q <= 1'b0;
    end
    else
    begin
      drv_q <= drv; sel_q <= sel; stp_q <= stp;
    end
  wire drv_in  = drv & ~drv_q;
  wire sel_tap = sel & ~sel_q;
  wire stp_tap = stp & ~stp_q;

  // ************************************************************
  // registers and bus
  // ************************************************************
  logic [8:0]  ival;
  logic [31:0] acid, rtc, fuel_left, burn, fuel_used, rd_idx;
  logic [3:0]  ctrl;
  logic        bit_mode, refuel_pulse, ival_chg;
  wire acc     = PSEL & PENABLE;
  wire wr      = acc & PWRITE;
  wire sec_tick;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      ival <= `EFDL_IVAL_RST; acid <= `EFDL_ACID_RST; ctrl <= 4'h0;
      bit_mode <= 1'b0; refuel_pulse <= 1'b0; ival_chg <= 1'b0;
      fuel_left <= 32'h0; burn <= 32'h0; rd_idx <= 32'h0;
    end
    else
    begin
      refuel_pulse <= 1'b0;
      ival_chg <= 1'b0;
      if (wr && PADDR == `EFDL_CTRL_OFF)
      begin
        ctrl <= PWDATA[3:0];
        refuel_pulse <= PWDATA[`EFDL_CTRL_REFUEL];
        bit_mode <= PWDATA[`EFDL_CTRL_BIT];
      end
      else if (wr && PADDR == `EFDL_IVAL_OFF)
      begin
        if (PWDATA[8:0] >= `EFDL_IVAL_MIN && PWDATA[8:0] <= `EFDL_IVAL_MAX
            && PWDATA[31:9] == 23'h0)
        begin
          ival <= PWDATA[8:0]; // RQ2
          ival_chg <= (PWDATA[8:0] != ival); // RQ3
        end
      end
      else if (wr && PADDR == `EFDL_ACID_OFF)
        acid <= PWDATA; // RQ7
      else if (wr && PADDR == `EFDL_FUEL_OFF)
        fuel_left <= PWDATA;
      else if (wr && PADDR == `EFDL_CALC_OFF)
        burn <= PWDATA;
      else if (wr && PADDR == `EFDL_DUMP_OFF)
        rd_idx <= PWDATA;
    end

  // real-time clock, settable, counts seconds
  logic [25:0] presc;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST) presc <= 26'h0;
    else if (presc == 26'(SEC_CYC - 1)) presc <= 26'h0;
    else presc <= presc + 26'h1;
  assign sec_tick = (presc == 26'(SEC_CYC - 1));
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST) rtc <= 32'h0;
    else if (wr && PADDR == `EFDL_TIME_OFF) rtc <= PWDATA; // RQ6
    else if (sec_tick) rtc <= rtc + 32'h1;

  // ************************************************************
  // recording
  // ************************************************************
  logic [31:0] mem [`EFDL_MEM_DEPTH];
  logic [5:0]  wptr, new_base;
  logic [6:0]  fill_all, fill_new;
  logic [8:0]  sec_cnt;
  logic        flying;
  logic [7:0]  flight;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      flying <= 1'b0; sec_cnt <= `EFDL_IVAL_RST; flight <= 8'h0;
    end
    else
    begin
      if (!flying && EGT_AVG > `EFDL_EGT_START)
      begin
        flying <= 1'b1; // RQ4
        flight <= flight + 8'h1;
        sec_cnt <= ival;
      end
      else if (flying && ival_chg)
      begin
        flight <= flight + 8'h1; // RQ3
        sec_cnt <= ival;
      end
      else if (flying && sec_tick)
        sec_cnt <= (sec_cnt <= 9'h1) ? ival : sec_cnt - 9'h1; // RQ22
    end
  wire rec_now = flying && sec_tick && sec_cnt <= 9'h1 && !ival_chg; // RQ1
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      wptr <= 6'h0; fill_all <= 7'h0;
    end
    else if (rec_now)
    begin
      wptr <= wptr + 6'h1; // RQ5
      if (fill_all != 7'(`EFDL_MEM_DEPTH)) fill_all <= fill_all + 7'h1;
    end
  always_ff @(posedge CLOCK)
    if (rec_now)
      mem[wptr] <= {flight, rtc[11:0], EGT_AVG}; // RQ1 RQ6

  // ************************************************************
  // scan filter and derived items
  // ************************************************************
  logic [4:0] item;
  logic [`EFDL_ITEM_CNT-1:0] t_ok, f_ok, show;
  // items 0..6 temperature, 7 speed/pressure, 8..14 fuel, 15..20 temperature
  genvar gi;
  for (gi = 0; gi < `EFDL_ITEM_CNT; gi++)
  begin : g_item
    assign t_ok[gi] = (gi < 7) || (gi == 7) || (gi >= 15);
    assign f_ok[gi] = (gi >= 7 && gi <= 14);
    assign show[gi] = ((sw == EFDL_SW_ALL) ||
                       (sw == EFDL_SW_TEMP && t_ok[gi]) ||
                       (sw == EFDL_SW_FUEL && f_ok[gi])) && // RQ20 RQ14
                      !(gi == 5 && ctrl[`EFDL_CTRL_CDT_INST]) && // RQ15
                      !((gi == 9 || gi == 10) && !ctrl[`EFDL_CTRL_NAV_OK]); // RQ16
  end
  wire [4:0] item_nx = (item == 5'(`EFDL_ITEM_CNT - 1)) ? 5'h0 : item + 5'h1;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST) item <= 5'h0;
    else if (sec_tick) item <= item_nx; // RQ14
    else if (!show[item]) item <= item_nx;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      SCAN_ITEM <= 5'h0; SCAN_ALARM <= 1'b0;
      SPREAD_VALUE <= 12'h0; SPREAD_CYL <= 3'h0;
    end
    else
    begin
      if (show[item]) SCAN_ITEM <= item;
      SCAN_ALARM <= alm; // RQ21
      SPREAD_VALUE <= EGT_HOT - EGT_COLD; // RQ17
      SPREAD_CYL <= ((EGT_HOT - EGT_AVG) >= (EGT_AVG - EGT_COLD)) ? HOT_CYL : COLD_CYL; // RQ17
    end

  // endurance in minutes, computed serially, and fuel used
  logic [31:0] num, endur;
  logic [5:0]  dstep;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      num <= 32'h0; endur <= 32'h0; dstep <= 6'h0;
    end
    else if (dstep == 6'h0)
    begin
      num <= fuel_left * 32'd60; dstep <= 6'h1; endur <= 32'h0;
    end
    else if (burn != 32'h0 && num >= burn)
      begin num <= num - burn; endur <= endur + 32'h1; end // RQ18
    else
      dstep <= 6'h0;
  logic [31:0] endur_hm;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST) endur_hm <= 32'h0;
    else if (dstep == 6'h0 && burn != 32'h0)
      endur_hm <= {16'(endur / 32'd60), 16'(endur % 32'd60)}; // RQ18
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST) fuel_used <= 32'h0;
    else if (refuel_pulse && !ctrl[`EFDL_CTRL_ACCUM]) fuel_used <= 32'h0; // RQ19
    else if (sec_tick) fuel_used <= fuel_used + burn;

  // ************************************************************
  // download
  // ************************************************************
  efdl_dump_t st;
  efdl_opt_t  opt;
  logic [6:0] left, total;
  logic [5:0] rptr;
  logic       id_sent;
  assign fill_new = (7'(wptr) - 7'(new_base)) & 7'h3F;
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      st <= EFDL_IDLE; opt <= EFDL_OPT_NEW; left <= 7'h0; total <= 7'h0;
      rptr <= 6'h0; new_base <= 6'h0; id_sent <= 1'b0;
      DRIVE_VALID <= 1'b0; DRIVE_DATA <= 32'h0; DUMP_DONE <= 1'b0;
    end
    else
    begin
      case (st)
        EFDL_IDLE:
          if (drv_in && !alm) // RQ10
          begin
            st <= EFDL_MENU; opt <= EFDL_OPT_NEW; // RQ9
          end
        EFDL_MENU:
          if (!drv) st <= EFDL_IDLE;
          else if (sel_tap) // RQ11
            opt <= (opt == EFDL_OPT_EXIT) ? EFDL_OPT_NEW : efdl_opt_t'(opt + 2'h1);
          else if (stp_tap)
          begin
            if (opt == EFDL_OPT_EXIT) st <= EFDL_IDLE;
            else
            begin
              st <= EFDL_XFER; id_sent <= 1'b0;
              left  <= (opt == EFDL_OPT_ALL) ? fill_all : fill_new;
              total <= (opt == EFDL_OPT_ALL) ? fill_all : fill_new;
              rptr  <= (opt == EFDL_OPT_ALL) ? wptr - fill_all[5:0] : new_base;
            end
          end
        EFDL_XFER:
          if (!drv) begin st <= EFDL_IDLE; DRIVE_VALID <= 1'b0; end
          else if (DRIVE_VALID && !DRIVE_READY) ;
          else if (!id_sent)
          begin
            DRIVE_VALID <= 1'b1; DRIVE_DATA <= acid; id_sent <= 1'b1; // RQ7
          end
          else if (left != 7'h0)
          begin
            DRIVE_VALID <= 1'b1; DRIVE_DATA <= mem[rptr]; // RQ8
            rptr <= rptr + 6'h1; left <= left - 7'h1;
          end
          else
          begin
            DRIVE_VALID <= 1'b0; new_base <= wptr; st <= EFDL_DONE; DUMP_DONE <= 1'b1;
          end
        EFDL_DONE:
          if (sec_tick) begin st <= EFDL_IDLE; DUMP_DONE <= 1'b0; end // RQ12
        default:
          st <= EFDL_IDLE;
      endcase
    end
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST) begin DUMP_CHOICE <= 2'h0; DUMP_PERCENT <= 7'h0; end
    else
    begin
      DUMP_CHOICE <= opt;
      DUMP_PERCENT <= (total == 7'h0) ? 7'd100 :
                      7'(((14'(total - left)) * 14'd100) / 14'(total)); // RQ12
    end

  // ************************************************************
  // bus read path
  // ************************************************************
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      PRDATA <= 32'h0; PREADY <= 1'b0; PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      if (PSEL && !PENABLE)
      begin
        if (PADDR == `EFDL_CTRL_OFF) PRDATA <= {27'h0, bit_mode, ctrl};
        else if (PADDR == `EFDL_IVAL_OFF) PRDATA <= {23'h0, ival};
        else if (PADDR == `EFDL_ACID_OFF) PRDATA <= acid;
        else if (PADDR == `EFDL_TIME_OFF) PRDATA <= rtc;
        else if (PADDR == `EFDL_STAT_OFF) // RQ13
          PRDATA <= {flight, 1'b0, 7'((14'(fill_new) * 14'd100) >> 6), 8'h0, 4'h0, st};
        else if (PADDR == `EFDL_WPTR_OFF) PRDATA <= {26'h0, wptr};
        else if (PADDR == `EFDL_DUMP_OFF) PRDATA <= rd_idx;
        else if (PADDR == `EFDL_RDAT_OFF) PRDATA <= mem[rd_idx[5:0]];
        else if (PADDR == `EFDL_SENS_OFF) PRDATA <= {17'h0, SPREAD_CYL, SPREAD_VALUE};
        else if (PADDR == `EFDL_SCAN_OFF) PRDATA <= {27'h0, SCAN_ITEM};
        else if (PADDR == `EFDL_FUEL_OFF) PRDATA <= fuel_used;
        else if (PADDR == `EFDL_CALC_OFF) PRDATA <= endur_hm;
        else
        begin
          PRDATA <= 32'h0; PSLVERR <= 1'b1;
        end
      end
    end
endmodule // efdl_logger

// ### testbench/efdl_logger_checker.sv
// port assertions for the flight data logger
`timescale 1ns/100ps
module efdl_logger_checker
(
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [11:0] EGT_HOT,
  input wire logic [11:0] EGT_COLD,
  input wire logic [2:0]  HOT_CYL,
  input wire logic [2:0]  COLD_CYL,
  input wire logic [11:0] EGT_AVG,
  input wire logic        ALARM_PENDING,
  input wire logic        SCAN_ALARM,
  input wire logic        DRIVE_VALID,
  input wire logic        DRIVE_READY,
  input wire logic [31:0] DRIVE_DATA,
  input wire logic        DUMP_DONE,
  input wire logic [6:0]  DUMP_PERCENT,
  input wire logic [11:0] SPREAD_VALUE,
  input wire logic [2:0]  SPREAD_CYL
);
  logic [3:0] up_cnt;
  logic       up_ok;
  // hold the spread and alarm checks off until the synchronisers have refilled after reset
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
      up_cnt <= 4'h0;
    else if (!up_ok)
      up_cnt <= up_cnt + 4'h1;
  assign up_ok = (up_cnt == 4'hF);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence seq_egt_steady;
    (up_ok && $stable(EGT_HOT) && $stable(EGT_COLD) && $stable(HOT_CYL)
     && $stable(COLD_CYL) && $stable(EGT_AVG))[*3];
  endsequence
  sequence seq_alarm_held;
    (up_ok && ALARM_PENDING)[*8];
  endsequence
  a_ready_access: assert property (PSEL && PENABLE |-> PREADY)
    else $error("ready missing in access phase");
  a_ready_setup: assert property (PSEL && !PENABLE |-> !PREADY)
    else $error("ready in setup phase");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_spread_value: assert property (seq_egt_steady |-> SPREAD_VALUE == EGT_HOT - EGT_COLD)
    else $error("spread value wrong");
  // the marked cylinder is the one farther from the average
  a_spread_cyl: assert property (seq_egt_steady |-> SPREAD_CYL ==
    (((EGT_HOT - EGT_AVG) >= (EGT_AVG - EGT_COLD)) ? HOT_CYL : COLD_CYL))
    else $error("spread cylinder wrong");
  a_alarm_shown: assert property (seq_alarm_held |-> SCAN_ALARM)
    else $error("alarm not shown");
  a_stream_hold: assert property (DRIVE_VALID && !DRIVE_READY |=> DRIVE_VALID && $stable(DRIVE_DATA))
    else $error("stream word dropped");
  a_done_quiet: assert property (DUMP_DONE |-> !DRIVE_VALID)
    else $error("stream active when done");
  a_pct_limit: assert property (DRIVE_VALID |-> DUMP_PERCENT <= 7'h64)
    else $error("percent above hundred");
endmodule // efdl_logger_checker

bind efdl_logger efdl_logger_checker u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .EGT_HOT(EGT_HOT),
  .EGT_COLD(EGT_COLD), .HOT_CYL(HOT_CYL), .COLD_CYL(COLD_CYL), .EGT_AVG(EGT_AVG),
  .ALARM_PENDING(ALARM_PENDING),
  .SCAN_ALARM(SCAN_ALARM), .DRIVE_VALID(DRIVE_VALID), .DRIVE_READY(DRIVE_READY),
  .DRIVE_DATA(DRIVE_DATA), .DUMP_DONE(DUMP_DONE), .DUMP_PERCENT(DUMP_PERCENT),
  .SPREAD_VALUE(SPREAD_VALUE), .SPREAD_CYL(SPREAD_CYL));

// ### testbench/efdl_drive_model.sv
// flash drive model taking the download word stream
`timescale 1ns/100ps
module efdl_drive_model
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        insert,
  input  wire logic        slow,
  input  wire logic        drive_valid,
  input  wire logic [31:0] drive_data,
  output logic             drive_present,
  output logic             drive_ready,
  output logic [31:0]      first_word,
  output logic [7:0]       n_words
);
  assign drive_present = insert;
  // slow drive accepts every other cycle
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      drive_ready <= 1'b0;
    else
      drive_ready <= slow ? ~drive_ready : 1'b1;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      first_word <= 32'h0;
      n_words    <= 8'h0;
    end
    else if (drive_valid && drive_ready)
    begin
      if (n_words == 8'h0)
        first_word <= drive_data;
      n_words <= n_words + 8'h1;
    end
endmodule // efdl_drive_model

// ### testbench/tb_top.sv
// self-checking bench for the flight data logger
`timescale 1ns/100ps
`include "efdl_cfg.svh"
module tb_top;
  import efdl_pkg::*;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        sel_b, step_b, alarm, insert, slow, present, ready, valid, done, scan_alarm;
  logic [11:0] paddr, egt_hot, egt_cold, egt_avg, spread;
  logic [31:0] pwdata, prdata, ddata, first_word, d;
  logic [2:0]  hot_cyl, cold_cyl, spread_cyl;
  logic [1:0]  choice, sel_sw;
  logic [6:0]  pct;
  logic [4:0]  scan_item;
  logic [7:0]  n_words;
  logic        err;
  int          n_errors, total_checks, cyc, n;
  logic [31:0] iv[4] = '{32'h1, 32'h1F5, 32'h2, 32'h1F4};
  logic [31:0] ex[4] = '{32'h6, 32'h6, 32'h2, 32'h1F4};

  efdl_logger u_dut (.CLOCK(clock), .SYS_RST(sys_rst), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EGT_HOT(egt_hot), .EGT_COLD(egt_cold), .HOT_CYL(hot_cyl),
    .COLD_CYL(cold_cyl), .EGT_AVG(egt_avg), .DRIVE_PRESENT(present), .SELECT_BUTTON(sel_b),
    .STEP_BUTTON(step_b), .ALARM_PENDING(alarm), .SELECT_SWITCH(sel_sw),
    .DRIVE_READY(ready), .DRIVE_VALID(valid), .DRIVE_DATA(ddata), .DUMP_CHOICE(choice),
    .DUMP_PERCENT(pct), .DUMP_DONE(done), .SCAN_ITEM(scan_item), .SCAN_ALARM(scan_alarm),
    .SPREAD_VALUE(spread), .SPREAD_CYL(spread_cyl));
  efdl_drive_model u_drive (.clock(clock), .sys_rst(sys_rst), .insert(insert), .slow(slow),
    .drive_valid(valid), .drive_data(ddata), .drive_present(present), .drive_ready(ready),
    .first_word(first_word), .n_words(n_words));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ***********************
  // shared tasks
  // ***********************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; ready and data are taken at the rising edge that samples ready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && k < 50)
    begin
      k++;
      @(posedge clock);
    end
    d   = prdata;
    err = pslverr;
    if (k >= 50)
      n_errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tap(input logic stp);
    if (stp)
      step_b <= 1'b1;
    else
      sel_b <= 1'b1;
    repeat (10) @(posedge clock);
    step_b <= 1'b0;
    sel_b  <= 1'b0;
    repeat (10) @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // ***********************
  // test sequence
  // ***********************
  initial
  begin
    {sys_rst, psel, penable, pwrite, sel_b, step_b, alarm, insert, slow} = 9'h100;
    {paddr, pwdata} = '0;
    sel_sw = EFDL_SW_ALL;
    {egt_hot, egt_cold, hot_cyl, cold_cyl} = '0;
    egt_avg = `EFDL_EGT_START;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, `EFDL_IVAL_OFF, 32'h0);
    check("interval reset", d, 32'h6);
    apb(1'b0, `EFDL_ACID_OFF, 32'h0);
    check("id reset", d, `EFDL_ACID_RST);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `EFDL_IVAL_OFF, iv[i]);
      apb(1'b0, `EFDL_IVAL_OFF, 32'h0);
      check("interval", d, ex[i]);
    end
    apb(1'b0, 12'h030, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", d, 32'h0);
    apb(1'b0, `EFDL_STAT_OFF, 32'h0);
    check("no flight at threshold", {24'h0, d[31:24]}, 32'h0);
    $display("test registers done");
    egt_avg  <= 12'h500;
    egt_hot  <= 12'h53C;
    egt_cold <= 12'h4EC;
    hot_cyl  <= 3'h3;
    cold_cyl <= 3'h5;
    repeat (10) @(posedge clock);
    check("spread", {20'h0, spread}, 32'h50);
    check("spread cyl", {29'h0, spread_cyl}, 32'h3);
    egt_hot <= 12'h514;
    egt_cold <= 12'h47E;
    repeat (10) @(posedge clock);
    check("spread", {20'h0, spread}, 32'h96);
    check("spread cyl", {29'h0, spread_cyl}, 32'h5);
    $display("test spread done");
    apb(1'b0, `EFDL_STAT_OFF, 32'h0);
    check("flight opened", {24'h0, d[31:24]}, 32'h1);
    apb(1'b1, `EFDL_IVAL_OFF, 32'h3);
    apb(1'b0, `EFDL_STAT_OFF, 32'h0);
    check("flight reopened", {24'h0, d[31:24]}, 32'h2);
    sel_sw <= EFDL_SW_FUEL;
    repeat (20) @(posedge clock);
    check("scan fuel", {27'h0, scan_item}, 32'h7);
    sel_sw <= EFDL_SW_TEMP;
    repeat (20) @(posedge clock);
    check("scan temp", {27'h0, scan_item}, 32'h7);
    $display("test flight and scan done");
    alarm  <= 1'b1;
    insert <= 1'b1;
    repeat (20) @(posedge clock);
    check("alarm shown", {31'h0, scan_alarm}, 32'h1);
    apb(1'b0, `EFDL_STAT_OFF, 32'h0);
    check("state blocked", {28'h0, d[3:0]}, {28'h0, EFDL_IDLE});
    alarm  <= 1'b0;
    insert <= 1'b0;
    repeat (20) @(posedge clock);
    insert <= 1'b1;
    repeat (20) @(posedge clock);
    apb(1'b0, `EFDL_STAT_OFF, 32'h0);
    check("state menu", {28'h0, d[3:0]}, {28'h0, EFDL_MENU});
    check("choice", {30'h0, choice}, {30'h0, EFDL_OPT_NEW});
    tap(1'b0);
    check("choice", {30'h0, choice}, {30'h0, EFDL_OPT_ALL});
    tap(1'b0);
    check("choice", {30'h0, choice}, {30'h0, EFDL_OPT_EXIT});
    tap(1'b1);
    apb(1'b0, `EFDL_STAT_OFF, 32'h0);
    check("state exit", {28'h0, d[3:0]}, {28'h0, EFDL_IDLE});
    $display("test menu done");
    apb(1'b1, `EFDL_ACID_OFF, 32'hCAFE_0001);
    insert <= 1'b0;
    slow   <= 1'b1;
    repeat (20) @(posedge clock);
    insert <= 1'b1;
    repeat (20) @(posedge clock);
    tap(1'b0);
    tap(1'b1);
    n = 0;
    while (done !== 1'b1 && n < 5000)
    begin
      @(posedge clock);
      n++;
    end
    check("done", {31'h0, done}, 32'h1);
    check("first word", first_word, 32'hCAFE_0001);
    check("word count", {24'h0, n_words}, 32'h1);
    check("percent", {25'h0, pct}, 32'h64);
    $display("test download done");
    end_sim();
  end
endmodule // tb_top
